// [lcd_pkg.sv]
package lcd_pkg;

    // --------------------
    // Timing
    // --------------------
    localparam int CLK_MHZ  = 40;
    // Init time after reset, ns
    localparam int INIT_NS  = 1000;
    localparam int INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W    = 16;

    // --------------------
    // Display RAM geometry
    // --------------------
    localparam int         NUM_COLS  = 132;
    localparam int         NUM_PAGES = 9;
    localparam logic [7:0] COL_LAST  = 8'h83;
    localparam logic [7:0] COL_END   = 8'h84;
    localparam logic [3:0] PAGE_IND  = 4'h8;
    localparam logic [7:0] IND_MASK  = 8'h01;

    // --------------------
    // Command codes
    // --------------------
    localparam logic [6:0] CMD_DISP   = 7'h57;
    localparam logic [6:0] CMD_SEG    = 7'h50;
    localparam logic [7:0] CMD_RESET  = 8'hE2;
    localparam logic [1:0] CMD_START  = 2'h1;
    localparam logic [3:0] CMD_PAGE   = 4'hB;
    localparam logic [3:0] CMD_COL_HI = 4'h1;
    localparam logic [3:0] CMD_COL_LO = 4'h0;

    // --------------------
    // Status byte bit positions
    // --------------------
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_SEG_BIT  = 6;
    localparam int ST_OFF_BIT  = 5;
    localparam int ST_INIT_BIT = 4;

    // --------------------
    // Reset values
    // --------------------
    localparam logic       DISP_RST  = 1'b0;
    localparam logic       SEG_RST   = 1'b0;
    localparam logic [5:0] START_RST = 6'h00;
    localparam logic [7:0] COL_RST   = 8'h00;
    localparam logic [3:0] PAGE_RST  = 4'h0;

    // --------------------
    // Types
    // --------------------
    typedef struct packed {
        logic       cd;
        logic [7:0] data;
    } lcd_xfer_t;

    typedef enum logic [2:0] {
        LCD_RUN  = 3'b001,
        LCD_INIT = 3'b010,
        LCD_HOLD = 3'b100
    } lcd_state_t;

endpackage : lcd_pkg

// [lcd_ram.sv]
`timescale 1ns/100ps

module lcd_ram
    import lcd_pkg::*;
#(
    parameter int COLS  = NUM_COLS,
    parameter int PAGES = NUM_PAGES
) (
    input  wire logic       clk,      // Core clock
    input  wire logic       wr_en,    // Host write strobe
    input  wire logic [3:0] wr_page,  // Host write page
    input  wire logic [7:0] wr_col,   // Host write column
    input  wire logic [7:0] wr_data,  // Host write byte
    input  wire logic [3:0] rd_page,  // Host read page
    input  wire logic [7:0] rd_col,   // Host read column
    output logic      [7:0] rd_data,  // Host read byte, registered
    input  wire logic [3:0] dp_page,  // Scan read page
    input  wire logic [7:0] dp_col,   // Scan read column
    output logic      [7:0] dp_data   // Scan read byte, registered
);

    if (COLS > 256 || PAGES > 16 || PAGES < 9) begin : g_bad_size
        $error("lcd_ram: unsupported geometry");
    end

    logic [7:0] mem [PAGES*COLS];

    function automatic int unsigned idx(input logic [3:0] p, input logic [7:0] c);
        idx = p * COLS + c;
    endfunction : idx

    function automatic logic in_range(input logic [3:0] p, input logic [7:0] c);
        in_range = (int'(p) < PAGES) && (int'(c) < COLS);
    endfunction : in_range

    // Indicator page keeps only its lowest bit
    always_ff @(posedge clk) begin
        if (wr_en && in_range(wr_page, wr_col)) begin
            mem[idx(wr_page, wr_col)] <= (wr_page == PAGE_IND) ? (wr_data & IND_MASK)
                                                               : wr_data;
        end
        rd_data <= in_range(rd_page, rd_col) ? mem[idx(rd_page, rd_col)] : 8'h00;
        dp_data <= in_range(dp_page, dp_col) ? mem[idx(dp_page, dp_col)] : 8'h00;
    end

endmodule : lcd_ram

// [lcd_cmd_dec.sv]
`timescale 1ns/100ps
// Contract
// - 8080 mode: read low pulse, write low pulse
// - 6800 mode: rw selects, enable high strobe
// - Serial bytes assembled most significant first
// - Commands run on internal clock only
// - Display on/off from command bit zero
// - Start line loaded from low six bits
// - Rows follow start line ascending, one clock later
// - Page command loads four bit page
// - Page change never alters shown image
// - Page eight indicator stores bit zero only
// - Column set by high and low nibbles
// - Data access advances column, stops 132
// - Status read shows init flag, low zeros
// - Busy rejects all commands and data
// - Order flag low maps column 131-n
// - Off flag is inverse of on state
// - Data write stores byte, column plus one
// - Data read returns byte, column plus one
// - First read after column set is dummy
// - Serial path supports no data reads
// - Segment order command selects column mapping
// - Hardware reset clears display state registers

module lcd_cmd_dec
    import lcd_pkg::*;
(
    input  wire logic       clk,             // 40 MHz core clock
    input  wire logic       rst_b,           // Async reset, active low
    input  wire logic       hard_reset_n,    // Device reset pin, active low
    input  wire logic       bus_6800,        // 1: 6800 style, 0: 8080 style
    input  wire logic       serial_sel,      // 1: serial input in use
    input  wire logic       cmd_data_select, // 0: command/status, 1: data
    input  wire logic       strobe_a,        // 8080 read_n / 6800 enable
    input  wire logic       strobe_b,        // 8080 write_n / 6800 read_write
    input  wire logic [7:0] data_in,         // Parallel data bus in
    output logic      [7:0] data_out,        // Parallel data bus out
    output logic            data_oe,         // Bus drive enable
    input  wire logic       ser_cs_n,        // Serial select, active low
    input  wire logic       ser_clk,         // Serial shift clock
    input  wire logic       ser_data,        // Serial data in
    input  wire logic [5:0] scan_row,        // Row index, 0 is first_row_driver
    input  wire logic [3:0] scan_page,       // Page being scanned
    input  wire logic [7:0] scan_seg,        // Segment driver number
    output logic      [5:0] scan_line,       // RAM line shown on scan_row
    output logic      [7:0] seg_data,        // RAM byte for scan_seg
    output logic            display_on,      // Display enabled
    output logic            seg_reverse,     // Segment order flag
    output logic      [5:0] start_line,      // Start display line
    output logic            busy             // Initialisation in progress
);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Strobe decoding
    // ------------------------------------------------------------
    logic       a_q;
    logic       b_q;
    logic       sclk_q;
    logic [7:0] sr;
    logic [2:0] bit_cnt;
    logic [7:0] next_sr;
    logic [2:0] next_bit_cnt;
    logic       wr_evt;
    logic       rd_beg;
    logic       rd_end;
    lcd_xfer_t  xfer;

    always_comb begin
        wr_evt       = 1'b0;
        rd_beg       = 1'b0;
        rd_end       = 1'b0;
        xfer.cd      = cmd_data_select;
        xfer.data    = data_in;
        next_sr      = sr;
        next_bit_cnt = bit_cnt;
        if (serial_sel) begin
            if (ser_cs_n) begin
                next_bit_cnt = 3'h0;
            end else if (ser_clk && !sclk_q) begin
                next_sr      = {sr[6:0], ser_data};
                next_bit_cnt = bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    wr_evt    = 1'b1;
                    xfer.data = {sr[6:0], ser_data};
                end
            end
        end else if (bus_6800) begin
            if (strobe_a && !a_q && strobe_b) begin
                rd_beg = 1'b1;
            end
            if (!strobe_a && a_q) begin
                wr_evt = !b_q;
                rd_end = b_q;
            end
        end else begin
            if (!strobe_a && a_q) begin
                rd_beg = 1'b1;
            end
            rd_end = strobe_a && !a_q;
            wr_evt = strobe_b && !b_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_q     <= 1'b1;
            b_q     <= 1'b1;
            sclk_q  <= 1'b0;
            sr      <= 8'h00;
            bit_cnt <= 3'h0;
        end else begin
            a_q     <= strobe_a;
            b_q     <= strobe_b;
            sclk_q  <= ser_clk;
            sr      <= next_sr;
            bit_cnt <= next_bit_cnt;
        end
    end

    // ------------------------------------------------------------
    // Command execution and addressing
    // ------------------------------------------------------------
    lcd_state_t       state;
    lcd_state_t       next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [7:0]       col;
    logic [7:0]       next_col;
    logic [3:0]       page;
    logic [3:0]       next_page;
    logic             next_display_on;
    logic             next_seg_reverse;
    logic [5:0]       next_start_line;
    logic             ram_we;
    logic             cmd_ok;

    always_comb begin
        next_state       = state;
        next_cnt         = cnt;
        next_col         = col;
        next_page        = page;
        next_display_on  = display_on;
        next_seg_reverse = seg_reverse;
        next_start_line  = start_line;
        ram_we           = 1'b0;
        cmd_ok           = wr_evt && (state == LCD_RUN);
        case (state)
            LCD_HOLD: begin
                if (hard_reset_n) begin
                    next_state = LCD_INIT;
                    next_cnt   = CNT_W'(INIT_CYC);
                end
            end
            LCD_INIT: begin
                next_cnt = cnt - 1'b1;
                if (cnt == 1) begin
                    next_state = LCD_RUN;
                end
            end
            LCD_RUN: begin
                if (cmd_ok && xfer.cd) begin
                    ram_we = 1'b1;
                    if (col != COL_END) begin
                        next_col = col + 8'h01;
                    end
                end else if (cmd_ok) begin
                    if (xfer.data[7:1] == CMD_DISP) begin
                        next_display_on = xfer.data[0];
                    end else if (xfer.data[7:1] == CMD_SEG) begin
                        next_seg_reverse = xfer.data[0];
                    end else if (xfer.data == CMD_RESET) begin
                        next_state      = LCD_INIT;
                        next_cnt        = CNT_W'(INIT_CYC);
                        next_start_line = START_RST;
                        next_col        = COL_RST;
                        next_page       = PAGE_RST;
                    end else if (xfer.data[7:6] == CMD_START) begin
                        next_start_line = xfer.data[5:0];
                    end else if (xfer.data[7:4] == CMD_PAGE) begin
                        next_page = xfer.data[3:0];
                    end else if (xfer.data[7:4] == CMD_COL_HI) begin
                        next_col = {xfer.data[3:0], col[3:0]};
                    end else if (xfer.data[7:4] == CMD_COL_LO) begin
                        next_col = {col[7:4], xfer.data[3:0]};
                    end
                end else if (rd_end && cmd_data_select) begin
                    if (col != COL_END) begin
                        next_col = col + 8'h01;
                    end
                end
            end
            default: begin
                next_state = LCD_HOLD;
            end
        endcase
        if (!hard_reset_n) begin
            next_state       = LCD_HOLD;
            next_cnt         = '0;
            next_col         = COL_RST;
            next_page        = PAGE_RST;
            next_display_on  = DISP_RST;
            next_seg_reverse = SEG_RST;
            next_start_line  = START_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= LCD_INIT;
            cnt         <= CNT_W'(INIT_CYC);
            col         <= COL_RST;
            page        <= PAGE_RST;
            display_on  <= DISP_RST;
            seg_reverse <= SEG_RST;
            start_line  <= START_RST;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            col         <= next_col;
            page        <= next_page;
            display_on  <= next_display_on;
            seg_reverse <= next_seg_reverse;
            start_line  <= next_start_line;
        end
    end

    // ------------------------------------------------------------
    // Read path and output latch
    // ------------------------------------------------------------
    logic [7:0] rd_ram;
    logic [7:0] rd_latch;
    logic [7:0] next_rd_latch;
    logic [1:0] ld_q;
    logic [1:0] next_ld_q;
    logic [7:0] next_data_out;
    logic       next_data_oe;
    logic       next_busy;
    logic [7:0] status;

    always_comb begin
        status              = 8'h00;
        status[ST_BUSY_BIT] = (state != LCD_RUN);
        status[ST_SEG_BIT]  = seg_reverse;
        status[ST_OFF_BIT]  = !display_on;
        status[ST_INIT_BIT] = (state != LCD_RUN);
        next_rd_latch = rd_latch;
        next_data_out = data_out;
        next_data_oe  = data_oe;
        next_busy     = (next_state != LCD_RUN);
        next_ld_q     = {ld_q[0], rd_end && cmd_data_select && (state == LCD_RUN)};
        if (ld_q[1]) begin
            next_rd_latch = rd_ram;
        end
        // Latch holds the previous fetch, hence the dummy read
        if (rd_beg) begin
            next_data_oe  = 1'b1;
            next_data_out = cmd_data_select ? rd_latch : status;
        end else if (rd_end || serial_sel) begin
            next_data_oe = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_latch <= 8'h00;
            ld_q     <= 2'h0;
            data_out <= 8'h00;
            data_oe  <= 1'b0;
            busy     <= 1'b1;
        end else begin
            rd_latch <= next_rd_latch;
            ld_q     <= next_ld_q;
            data_out <= next_data_out;
            data_oe  <= next_data_oe;
            busy     <= next_busy;
        end
    end

    // ------------------------------------------------------------
    // Display scan side
    // ------------------------------------------------------------
    logic [7:0] scan_col;
    logic [5:0] next_scan_line;

    always_comb begin
        scan_col       = seg_reverse ? scan_seg : COL_LAST - scan_seg;
        next_scan_line = start_line + scan_row;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_line <= 6'h00;
        end else begin
            scan_line <= next_scan_line;
        end
    end

    lcd_ram u_ram (
        .clk     (clk),
        .wr_en   (ram_we),
        .wr_page (page),
        .wr_col  (col),
        .wr_data (xfer.data),
        .rd_page (page),
        .rd_col  (col),
        .rd_data (rd_ram),
        .dp_page (scan_page),
        .dp_col  (scan_col),
        .dp_data (seg_data)
    );

endmodule : lcd_cmd_dec

// [lcd_cmd_dec_asserts.sv]
`timescale 1ns/100ps

module lcd_chk
    import lcd_pkg::*;
(
    input wire logic       clk,             // Clock
    input wire logic       rst_b,           // Reset, active low
    input wire logic       hard_reset_n,    // Device reset pin
    input wire logic       bus_6800,        // Bus style
    input wire logic       serial_sel,      // Serial in use
    input wire logic       cmd_data_select, // Command or data
    input wire logic       strobe_a,        // Read or enable
    input wire logic       strobe_b,        // Write or direction
    input wire logic [7:0] data_in,         // Bus in
    input wire logic [7:0] data_out,        // Bus out
    input wire logic       data_oe,         // Bus drive
    input wire logic [5:0] scan_row,        // Scanned row
    input wire logic [5:0] scan_line,       // Line shown
    input wire logic       display_on,      // Display state
    input wire logic       seg_reverse,     // Segment order
    input wire logic [5:0] start_line,      // Start line
    input wire logic       busy             // Busy
);
    logic [7:0] busy_cnt;
    logic [7:0] next_busy_cnt;

    // --------------------
    // Busy length
    // --------------------
    // Pin reset restarts the count
    always_comb begin
        next_busy_cnt = (busy && hard_reset_n) ? busy_cnt + 8'h01 : 8'h00;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end

    // --------------------
    // Properties
    // --------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence cmd_ev;
        !serial_sel && !cmd_data_select && !busy &&
        (bus_6800 ? ($fell(strobe_a) && !strobe_b) : ($rose(strobe_b) && strobe_a));
    endsequence

    AST_DISP_CMD: assert property (cmd_ev ##0 data_in[7:1] == CMD_DISP
        |=> display_on == $past(data_in[0])) else $error("disp");
    AST_SEG_CMD: assert property (cmd_ev ##0 data_in[7:1] == CMD_SEG
        |=> seg_reverse == $past(data_in[0])) else $error("seg");
    AST_START_CMD: assert property (cmd_ev ##0 data_in[7:6] == CMD_START
        |=> start_line == $past(data_in[5:0])) else $error("start");
    AST_STATUS: assert property ($rose(data_oe) && !cmd_data_select
        |-> data_out[3:0] == 4'h0 && data_out[ST_SEG_BIT] == seg_reverse
        && data_out[ST_OFF_BIT] == !display_on
        && data_out[ST_INIT_BIT] == data_out[ST_BUSY_BIT]) else $error("status");
    AST_SCAN_LINE: assert property ($past(rst_b, 3)
        |-> scan_line == 6'($past(start_line) + $past(scan_row))) else $error("scan");
    AST_HARD_RST: assert property (!hard_reset_n ##1 !hard_reset_n
        |=> !display_on && !seg_reverse && start_line == START_RST) else $error("reset");
    AST_BUSY_LEN: assert property ($fell(busy)
        |-> busy_cnt inside {[8'h26:8'h2C]}) else $error("busy len");
    AST_BUSY_HOLD: assert property (busy && hard_reset_n && $past(hard_reset_n)
        |=> $stable(display_on) && $stable(seg_reverse)) else $error("busy cmd");
    AST_OE_START: assert property (!serial_sel && strobe_b
        && (bus_6800 ? $rose(strobe_a) : $fell(strobe_a)) |=> data_oe) else $error("no drive");
    AST_OE_END: assert property (!serial_sel && data_oe
        && (bus_6800 ? $fell(strobe_a) && strobe_b : $rose(strobe_a)) |=> !data_oe)
        else $error("drive held");
    AST_SERIAL: assert property (serial_sel && $past(serial_sel) && $past(serial_sel, 2)
        |-> !data_oe) else $error("serial rd");
endmodule : lcd_chk

bind lcd_cmd_dec lcd_chk i_chk (.*);

// [lcd_host.sv]
`timescale 1ns/100ps

module lcd_host
    import lcd_pkg::*;
(
    input  wire logic       clk,             // Clock
    input  wire logic [7:0] data_out,        // Device read data
    input  wire logic       data_oe,         // Device drives bus
    output logic            bus_6800,        // Bus style
    output logic            serial_sel,      // Serial in use
    output logic            cmd_data_select, // Command or data
    output logic            strobe_a,        // Read or enable
    output logic            strobe_b,        // Write or direction
    output logic      [7:0] data_in,         // Bus out
    output logic            ser_cs_n,        // Serial select
    output logic            ser_clk,         // Serial clock
    output logic            ser_data         // Serial bit
);
    task automatic mode(input logic m6800, input logic ser);
        bus_6800   = m6800;
        serial_sel = ser;
        strobe_a   = !m6800;
        strobe_b   = 1'h1;
    endtask : mode

    initial begin
        mode(1'h0, 1'h0);
        cmd_data_select = 1'h0;
        data_in         = 8'h00;
        ser_cs_n        = 1'h1;
        ser_clk         = 1'h0;
        ser_data        = 1'h0;
    end

    // --------------------
    // Bus cycles
    // --------------------
    // write pulse per style
    task automatic wr(input lcd_xfer_t x);
        @(posedge clk);
        #2;
        cmd_data_select = x.cd;
        data_in         = x.data;
        strobe_b        = 1'h0;
        strobe_a        = 1'h1;
        @(posedge clk);
        #2;
        if (bus_6800) begin
            strobe_a = 1'h0;
        end else begin
            strobe_b = 1'h1;
        end
        @(posedge clk);
        #2;
        // Released bus shows inverse data
        data_in  = ~x.data;
        strobe_b = 1'h1;
        repeat (2) @(posedge clk);
        #2;
    endtask : wr

    task automatic rd(input logic cd, output logic [7:0] d);
        @(posedge clk);
        #2;
        cmd_data_select = cd;
        strobe_a        = bus_6800;
        repeat (3) @(posedge clk);
        #2;
        d        = data_out;
        strobe_a = !bus_6800;
        // Gap for latch refill
        repeat (5) @(posedge clk);
        #2;
    endtask : rd

    task automatic ser_wr(input lcd_xfer_t x);
        @(posedge clk);
        #2;
        cmd_data_select = x.cd;
        ser_cs_n        = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            ser_data = x.data[i];
            @(posedge clk);
            #2;
            ser_clk = 1'h1;
            @(posedge clk);
            #2;
            ser_clk = 1'h0;
        end
        ser_data = !x.data[0];
        ser_cs_n = 1'h1;
        repeat (2) @(posedge clk);
        #2;
    endtask : ser_wr
endmodule : lcd_host

// [tb.sv]
`timescale 1ns/100ps

module tb
    import lcd_pkg::*;
;
    logic       clk = 1'h0;
    logic       rst_b, hard_reset_n, bus_6800, serial_sel, cmd_data_select;
    logic       strobe_a, strobe_b, data_oe, ser_cs_n, ser_clk, ser_data;
    logic       display_on, seg_reverse, busy, dummy, on_m, rev_m;
    logic [7:0] data_in, data_out, scan_seg, seg_data, col, c, rd_v;
    logic [5:0] scan_row, scan_line, start_line, start_m;
    logic [3:0] scan_page, page, p;
    logic [7:0] ram [0:8][0:131];
    logic [7:0] cmds [0:4] = '{8'hAF, 8'hA1, 8'hAE, 8'hA0, 8'hAF};
    int         errors = 0;
    int         compares = 0;
    int         cycles = 0;

    lcd_cmd_dec i_lcd_cmd_dec (.*);
    lcd_host    u_host (.*);

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // --------------------
    // Model
    // --------------------
    function automatic logic [7:0] exp_status(input logic b, input logic r, input logic on);
        return {b, r, !on, b, 4'h0};
    endfunction : exp_status

    function automatic logic [7:0] exp_byte(input logic [3:0] pg, input logic [7:0] d);
        return (pg == PAGE_IND) ? (d & IND_MASK) : d;
    endfunction : exp_byte

    task automatic send(input logic cd, input logic [7:0] b);
        if (serial_sel) begin
            u_host.ser_wr('{cd, b});
        end else begin
            u_host.wr('{cd, b});
        end
        if (cd) begin
            if (col < COL_END) begin
                ram[page][col] = exp_byte(page, b);
                col++;
            end
        end else if (b[7:1] == CMD_DISP) on_m = b[0];
        else if (b[7:1] == CMD_SEG) rev_m = b[0];
        else if (b == CMD_RESET) begin
            page    = PAGE_RST;
            col     = COL_RST;
            start_m = START_RST;
        end else if (b[7:6] == CMD_START) start_m = b[5:0];
        else if (b[7:4] == CMD_PAGE) page = b[3:0];
        else if (b[7:4] == CMD_COL_HI) col[7:4] = b[3:0];
        else if (b[7:4] == CMD_COL_LO) col[3:0] = b[3:0];
        if (!cd && b[7:5] == 3'h0) dummy = 1'h1;
    endtask : send

    task automatic set_col(input logic [7:0] cc);
        send(1'h0, {CMD_COL_HI, cc[7:4]});
        send(1'h0, {CMD_COL_LO, cc[3:0]});
    endtask : set_col

    task automatic rdata();
        u_host.rd(1'h1, rd_v);
        if (!dummy) check("ram byte", rd_v, ram[page][col]);
        dummy = 1'h0;
        col++;
    endtask : rdata

    task automatic wait_idle();
        int n = 0;
        rd_v = 8'h80;
        while (rd_v[ST_BUSY_BIT] !== 1'h0 && n < 100) begin
            u_host.rd(1'h0, rd_v);
            n++;
        end
        check("busy poll", 8'(n == 100), 8'h00);
    endtask : wait_idle

    task automatic scan_chk(input logic [7:0] cc);
        scan_page = page;
        scan_seg  = rev_m ? cc : COL_LAST - cc;
        scan_row  = 6'($urandom);
        repeat (2) @(posedge clk);
        #2;
        check("seg data", seg_data, ram[page][cc]);
        check("scan line", 8'(scan_line), 8'(6'(start_m + scan_row)));
    endtask : scan_chk

    // --------------------
    // Stimulus
    // --------------------
    initial begin
        void'($urandom(7004));
        {rst_b, dummy, on_m, rev_m, start_m, page, col} = '0;
        {scan_row, scan_page, scan_seg} = '0;
        hard_reset_n = 1'h1;
        repeat (2) @(posedge clk);
        #2;
        rst_b = 1'h1;
        // Internal reset lifts two edges later
        repeat (3) @(posedge clk);
        wait_idle();
        u_host.rd(1'h0, rd_v);
        check("status", rd_v, exp_status(1'h0, 1'h0, 1'h0));
        for (int m = 0; m < 2; m++) begin
            u_host.mode(m[0], 1'h0);
            foreach (cmds[i]) begin
                send(1'h0, cmds[i]);
                u_host.rd(1'h0, rd_v);
                check("status", rd_v, exp_status(1'h0, rev_m, on_m));
                check("on", 8'(display_on), 8'(on_m));
                check("order", 8'(seg_reverse), 8'(rev_m));
            end
            send(1'h0, {CMD_START, 6'($urandom)});
            check("start", 8'(start_line), 8'(start_m));
            send(1'h0, {CMD_SEG, m[0]});
            p = 4'($urandom_range(8));
            c = 8'($urandom_range(128, 1));
            send(1'h0, {CMD_PAGE, p});
            set_col(c);
            repeat (3) send(1'h1, 8'($urandom));
            scan_chk(c);
            send(1'h0, {CMD_PAGE, 4'(p == 4'h0)});
            check("seg data", seg_data, ram[p][c]);
            send(1'h0, {CMD_PAGE, p});
            set_col(c - 8'h01);
            repeat (4) rdata();
        end
        u_host.mode(1'h0, 1'h0);
        send(1'h0, {CMD_PAGE, 4'h0});
        set_col(COL_LAST);
        repeat (2) send(1'h1, 8'($urandom));
        set_col(COL_LAST - 8'h01);
        repeat (2) rdata();
        u_host.mode(1'h0, 1'h1);
        send(1'h0, {CMD_PAGE, 4'h2});
        set_col(8'h0A);
        send(1'h1, 8'($urandom));
        send(1'h0, {CMD_START, 6'($urandom)});
        check("start", 8'(start_line), 8'(start_m));
        u_host.mode(1'h0, 1'h0);
        set_col(8'h09);
        repeat (2) rdata();
        send(1'h0, CMD_RESET);
        wait_idle();
        check("start", 8'(start_line), 8'(start_m));
        check("on", 8'(display_on), 8'(on_m));
        hard_reset_n = 1'h0;
        repeat (3) @(posedge clk);
        u_host.rd(1'h0, rd_v);
        check("status", rd_v, exp_status(1'h1, 1'h0, 1'h0));
        hard_reset_n = 1'h1;
        {on_m, rev_m, start_m, page, col} = '0;
        u_host.wr('{1'h0, 8'hAF});
        wait_idle();
        check("on", 8'(display_on), 8'h00);
        check("order", 8'(seg_reverse), 8'h00);
        check("start", 8'(start_line), 8'h00);
        repeat (2) send(1'h1, 8'($urandom));
        set_col(8'h00);
        repeat (2) rdata();
        end_sim();
    end
endmodule : tb
